// file: hw/adg_regs.sv
`timescale 1ns/100ps
`default_nettype none

module adg_regs
  import adg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output adg_power_t power,
  output logic [4:0] left_input_gain_sel,
  output logic [4:0] right_input_gain_sel,
  output logic [5:0] left_playback_gain_sel,
  output logic [5:0] right_playback_gain_sel
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  adg_state_t st;
  adg_state_t next_st;
  logic sck_rise;
  logic sck_fall;
  logic wr_commit;
  logic rd_load;
  logic [7:0] wr_data;

  // unused upper bits are never stored, so they cannot read back
  function automatic logic [7:0] read_mux(input adg_state_t s, input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADG_OFS_POWER: v = s.power;
      ADG_OFS_LIG_L: v = {3'h0, s.lig_l};
      ADG_OFS_LIG_R: v = {3'h0, s.lig_r};
      ADG_OFS_MPG_L: v = {2'h0, s.mpg_l};
      ADG_OFS_MPG_R: v = {2'h0, s.mpg_r};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // serial frame: 1 read flag, 7 address bits, 8 data bits, msb first
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    wr_commit = 1'b0;
    rd_load = 1'b0;
    wr_data = st.data;
    sck_rise = st.sck_sync[1] && !st.sck_prev;
    sck_fall = !st.sck_sync[1] && st.sck_prev;
    next_st.cs_sync = {st.cs_sync[0], spi_cs_n};
    next_st.sck_sync = {st.sck_sync[0], spi_sclk};
    next_st.mosi_sync = {st.mosi_sync[0], spi_mosi};
    // a third stage for the edge test, so no logic ever reads a settling flop
    next_st.sck_prev = st.sck_sync[1];
    if (st.cs_sync[1]) begin
      // deselect aborts any partial frame; nothing is committed
      next_st.bit_cnt = 5'h00;
      next_st.miso = 1'b0;
    end else if (sck_rise && st.bit_cnt != ADG_FRAME_BITS) begin
      // parks at the frame length so trailing clocks cannot wrap into a new frame
      next_st.bit_cnt = st.bit_cnt + 5'h01;
      if (st.bit_cnt <= ADG_CMD_LAST) begin
        next_st.cmd = {st.cmd[6:0], st.mosi_sync[1]};
      end else begin
        next_st.data = {st.data[6:0], st.mosi_sync[1]};
        wr_data = next_st.data;
      end
      if (st.bit_cnt == ADG_CMD_LAST && next_st.cmd[7]) begin
        rd_load = 1'b1;
        next_st.out_shift = read_mux(st, next_st.cmd[6:0]);
      end
      if (st.bit_cnt == ADG_FRAME_LAST && !st.cmd[7]) begin
        wr_commit = 1'b1;
        unique case (st.cmd[6:0])
          ADG_OFS_POWER: begin
            next_st.power.amp_driver_power_on = wr_data[ADG_BIT_AMP];
            next_st.power.aux_amp_power_on = wr_data[ADG_BIT_AUX];
            next_st.power.right_converter_power_on = wr_data[ADG_BIT_CONV_R];
            next_st.power.left_converter_power_on = wr_data[ADG_BIT_CONV_L];
            next_st.power.right_lineout_power_on = wr_data[ADG_BIT_LO_R];
            next_st.power.left_lineout_power_on = wr_data[ADG_BIT_LO_L];
            next_st.power.right_linein_power_on = wr_data[ADG_BIT_LI_R];
            next_st.power.left_linein_power_on = wr_data[ADG_BIT_LI_L];
          end
          ADG_OFS_LIG_L: next_st.lig_l = wr_data[4:0];
          ADG_OFS_LIG_R: next_st.lig_r = wr_data[4:0];
          ADG_OFS_MPG_L: next_st.mpg_l = wr_data[5:0];
          ADG_OFS_MPG_R: next_st.mpg_r = wr_data[5:0];
          default: begin
          end
        endcase
      end
    end else if (sck_fall && st.bit_cnt >= ADG_DATA_FIRST && st.bit_cnt != ADG_FRAME_BITS) begin
      // shift on the falling edge so the master samples a settled bit
      next_st.miso = st.out_shift[7];
      next_st.out_shift = {st.out_shift[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // clearing the whole struct first keeps counter and shifters at a known idle
      st <= '0;
      // select starts deselected so a pin glitch at release cannot open a frame
      st.cs_sync <= 2'h3;
      st.power <= ADG_RST_POWER;
      st.lig_l <= ADG_RST_LIG;
      st.lig_r <= ADG_RST_LIG;
      st.mpg_l <= ADG_RST_MPG;
      st.mpg_r <= ADG_RST_MPG;
    end else begin
      st <= next_st;
    end
  end

  assign spi_miso = st.miso;
  assign power = st.power;
  assign left_input_gain_sel = st.lig_l;
  assign right_input_gain_sel = st.lig_r;
  assign left_playback_gain_sel = st.mpg_l;
  assign right_playback_gain_sel = st.mpg_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_wr_to(logic [6:0] a);
    wr_commit && st.cmd[6:0] == a;
  endsequence

  a_amp_power_write: assert property (s_wr_to(ADG_OFS_POWER) |=> power.amp_driver_power_on == $past(wr_data[7]))
    else $error("amplifier driver enable did not follow write");
  a_aux_power_write: assert property (s_wr_to(ADG_OFS_POWER) |=> power.aux_amp_power_on == $past(wr_data[6]))
    else $error("aux amplifier enable did not follow write");
  a_lineout_power_write: assert property (s_wr_to(ADG_OFS_POWER)
    |=> {power.right_lineout_power_on, power.left_lineout_power_on} == $past(wr_data[3:2]))
    else $error("line-out enables did not follow write");
  a_linein_power_write: assert property (s_wr_to(ADG_OFS_POWER)
    |=> {power.right_linein_power_on, power.left_linein_power_on} == $past(wr_data[1:0]))
    else $error("line-in enables did not follow write");
  a_conv_power_write: assert property (s_wr_to(ADG_OFS_POWER)
    |=> {power.right_converter_power_on, power.left_converter_power_on} == $past(wr_data[5:4]))
    else $error("converter enables did not follow write");
  a_power_reset_zero: assert property ($fell(sys_rst) |-> power == ADG_RST_POWER)
    else $error("power enables not zero after reset");
  a_lig_l_reset: assert property ($fell(sys_rst) |-> left_input_gain_sel == ADG_RST_LIG)
    else $error("left line-in gain reset value wrong");
  a_lig_r_write: assert property (s_wr_to(ADG_OFS_LIG_R) |=> right_input_gain_sel == $past(wr_data[4:0]))
    else $error("right line-in gain did not follow write");
  a_mpg_l_reset: assert property ($fell(sys_rst) |-> left_playback_gain_sel == ADG_RST_MPG)
    else $error("left playback gain reset value wrong");
  a_mpg_r_write: assert property (s_wr_to(ADG_OFS_MPG_R) |=> right_playback_gain_sel == $past(wr_data[5:0]))
    else $error("right playback gain did not follow write");
  a_gain_upper_zero: assert property (rd_load && next_st.cmd[6:0] == ADG_OFS_LIG_L
    |=> st.out_shift[7:5] == 3'h0 ##0 st.out_shift[4:0] == left_input_gain_sel)
    else $error("left line-in gain readback wrong");
  a_no_write_hold: assert property (!wr_commit |=> $stable(power))
    else $error("power enables changed without a write");

  // ----------------------------------------------------------------
  // gain writes and resets
  // ----------------------------------------------------------------
  a_lig_l_write: assert property (s_wr_to(ADG_OFS_LIG_L)
    |=> left_input_gain_sel == $past(wr_data[4:0]))
    else $error("left line-in gain did not follow write");
  a_lig_r_reset: assert property ($fell(sys_rst) |-> right_input_gain_sel == ADG_RST_LIG)
    else $error("right line-in gain reset value wrong");
  a_mpg_l_write: assert property (s_wr_to(ADG_OFS_MPG_L)
    |=> left_playback_gain_sel == $past(wr_data[5:0]))
    else $error("left playback gain did not follow write");
  a_mpg_r_reset: assert property ($fell(sys_rst) |-> right_playback_gain_sel == ADG_RST_MPG)
    else $error("right playback gain reset value wrong");
  // gains move only on a committed write; a cut frame must leave them alone
  a_lig_hold: assert property (!wr_commit |=> $stable({left_input_gain_sel, right_input_gain_sel}))
    else $error("line-in gains changed without a write");
  a_mpg_hold: assert property (!wr_commit |=> $stable({left_playback_gain_sel, right_playback_gain_sel}))
    else $error("playback gains changed without a write");

  // ----------------------------------------------------------------
  // readback copies
  // ----------------------------------------------------------------
  // the copy is checked one edge after loading, before any falling edge can shift it
  sequence s_rd_of(logic [6:0] a);
    rd_load && next_st.cmd[6:0] == a;
  endsequence

  a_power_readback: assert property (s_rd_of(ADG_OFS_POWER) |=> st.out_shift == power)
    else $error("power enables readback wrong");
  a_lig_r_readback: assert property (s_rd_of(ADG_OFS_LIG_R)
    |=> st.out_shift == {3'h0, right_input_gain_sel})
    else $error("right line-in gain readback wrong");
  a_mpg_l_readback: assert property (s_rd_of(ADG_OFS_MPG_L)
    |=> st.out_shift == {2'h0, left_playback_gain_sel})
    else $error("left playback gain readback wrong");
  a_mpg_r_readback: assert property (s_rd_of(ADG_OFS_MPG_R)
    |=> st.out_shift == {2'h0, right_playback_gain_sel})
    else $error("right playback gain readback wrong");

endmodule

`default_nettype wire

// file: hw/adg_pkg.sv
package adg_pkg;

  // ----------------------------------------------------------------
  // register offsets on the serial control port
  // ----------------------------------------------------------------
  localparam logic [6:0] ADG_OFS_POWER = 7'h00;
  localparam logic [6:0] ADG_OFS_LIG_L = 7'h01;
  localparam logic [6:0] ADG_OFS_LIG_R = 7'h02;
  localparam logic [6:0] ADG_OFS_MPG_L = 7'h03;
  localparam logic [6:0] ADG_OFS_MPG_R = 7'h04;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] ADG_RST_POWER = 8'h00;
  localparam logic [4:0] ADG_RST_LIG = 5'h05;
  localparam logic [5:0] ADG_RST_MPG = 6'h08;

  // ----------------------------------------------------------------
  // field positions and frame counts
  // ----------------------------------------------------------------
  localparam int ADG_BIT_AMP = 7;
  localparam int ADG_BIT_AUX = 6;
  localparam int ADG_BIT_CONV_R = 5;
  localparam int ADG_BIT_CONV_L = 4;
  localparam int ADG_BIT_LO_R = 3;
  localparam int ADG_BIT_LO_L = 2;
  localparam int ADG_BIT_LI_R = 1;
  localparam int ADG_BIT_LI_L = 0;
  localparam logic [4:0] ADG_CMD_LAST = 5'h07;
  localparam logic [4:0] ADG_DATA_FIRST = 5'h08;
  localparam logic [4:0] ADG_FRAME_LAST = 5'h0F;
  localparam logic [4:0] ADG_FRAME_BITS = 5'h10;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic amp_driver_power_on;
    logic aux_amp_power_on;
    logic right_converter_power_on;
    logic left_converter_power_on;
    logic right_lineout_power_on;
    logic left_lineout_power_on;
    logic right_linein_power_on;
    logic left_linein_power_on;
  } adg_power_t;

  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] sck_sync;
    logic [1:0] mosi_sync;
    logic sck_prev;
    logic [4:0] bit_cnt;
    logic [7:0] cmd;
    logic [7:0] data;
    logic [7:0] out_shift;
    logic miso;
    adg_power_t power;
    logic [4:0] lig_l;
    logic [4:0] lig_r;
    logic [5:0] mpg_l;
    logic [5:0] mpg_r;
  } adg_state_t;

endpackage

// file: verification/adg_spi_master.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------
// serial port master standing in for the microcontroller
// ----------------
module adg_spi_master (
  input wire logic clk_sys,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // n under 16 aborts the frame, over 16 adds trailing ones
  task automatic xfer(input logic [15:0] f, input int n, input int half, output logic [7:0] q);
    q = 8'h00;
    spi_cs_n = 1'b0;
    tick(3);
    for (int k = 0; k < n; k++) begin
      spi_mosi = (k < 16) ? f[15-k] : 1'b1;
      tick(half);
      spi_sclk = 1'b1;
      if (k >= 8 && k < 16) q = {q[6:0], spi_miso};
      tick(half);
      spi_sclk = 1'b0;
    end
    tick(half);
    spi_cs_n = 1'b1;
    // released line flips so a stale level is never trusted
    spi_mosi = ~spi_mosi;
    tick(4);
  endtask
endmodule
`default_nettype wire

// file: verification/tb_audio_dac_power_gain_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_audio_dac_power_gain_regs;
  import adg_pkg::*;
  typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} adg_row_t;
  logic clk_sys, sys_rst, spi_cs_n, spi_sclk, spi_mosi, spi_miso;
  adg_power_t power;
  logic [4:0] left_input_gain_sel, right_input_gain_sel;
  logic [5:0] left_playback_gain_sel, right_playback_gain_sel;
  logic [7:0] rd;
  int bad_count = 0;
  int cmp_count = 0;
  logic [7:0] rst_e [5] = '{8'h00, 8'h05, 8'h05, 8'h08, 8'h08};
  adg_row_t rows [9] = '{'{7'h00, 8'h80, 8'h80}, '{7'h00, 8'h40, 8'h40}, '{7'h00, 8'h30, 8'h30},
    '{7'h00, 8'h0C, 8'h0C}, '{7'h01, 8'hFF, 8'h1F}, '{7'h02, 8'hEA, 8'h0A},
    '{7'h03, 8'hFF, 8'h3F}, '{7'h04, 8'hC5, 8'h05}, '{7'h00, 8'h03, 8'h03}};
  adg_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .power(power), .left_input_gain_sel(left_input_gain_sel),
    .right_input_gain_sel(right_input_gain_sel), .left_playback_gain_sel(left_playback_gain_sel),
    .right_playback_gain_sel(right_playback_gain_sel));
  adg_spi_master mst (.clk_sys(clk_sys), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] port_val(input logic [6:0] a);
    case (a)
      ADG_OFS_POWER: port_val = power;
      ADG_OFS_LIG_L: port_val = {3'h0, left_input_gain_sel};
      ADG_OFS_LIG_R: port_val = {3'h0, right_input_gain_sel};
      ADG_OFS_MPG_L: port_val = {2'h0, left_playback_gain_sel};
      ADG_OFS_MPG_R: port_val = {2'h0, right_playback_gain_sel};
      default: port_val = 8'h00;
    endcase
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n, input int half);
    mst.xfer({1'b0, a, d}, n, half, rd);
  endtask
  task automatic rdreg(input logic [6:0] a, input int half);
    mst.xfer({1'b1, a, 8'h00}, 16, half, rd);
  endtask
  // ----------------
  // reset values at the ports and through reads
  // ----------------
  task automatic chk_rst();
    for (int i = 0; i < 5; i++) begin
      chk8(port_val(7'(i)), rst_e[i]);
      rdreg(7'(i), 5);
      chk8(rd, rst_e[i]);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    chk_rst();
    // alternate prompt and slow serial clocks
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, 16, (i % 2) ? 8 : 5);
      chk8(port_val(rows[i].a), rows[i].e);
      rdreg(rows[i].a, (i % 2) ? 5 : 8);
      chk8(rd, rows[i].e);
    end
    // ----------------
    // aborted frame, overlong frame, unmapped address, reset in mid-run
    // ----------------
    wr(7'h00, 8'hFF, 10, 5);
    chk8(power, 8'h03);
    wr(7'h00, 8'hA5, 20, 5);
    chk8(power, 8'hA5);
    wr(7'h7F, 8'hFF, 16, 5);
    rdreg(7'h7F, 5);
    chk8(rd, 8'h00);
    chk8(power, 8'hA5);
    @(posedge clk_sys);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    chk_rst();
    tally_and_finish();
  end
endmodule
`default_nettype wire
